// >>> design/asp_params.svh
// Constants for the audio sample packer: sources, markers, slot counts.
// Assumes inclusion by bare name; definitions only.
`ifndef ASP_PARAMS_SVH
`define ASP_PARAMS_SVH
`define ASP_SRC_PACKED_ALL 5'h10
`define ASP_SRC_PAIR_OUT 5'h13
`define ASP_SRC_PAIR_MIC 5'h14
`define ASP_SRC_PAIR_REF 5'h15
`define ASP_MARK_0 8'h00
`define ASP_MARK_1 8'h01
`define ASP_MARK_2 8'h02
`define ASP_ALL_MARK_BASE 8'h10
`define ASP_SLOTS 2'h3
`define ASP_RATE_48K 2'h1
`define ASP_FIFO_DEPTH 32
`define ASP_WORD_W 32
`endif

// >>> design/asp_pkg.sv
// Types for the audio sample packer.
// Assumes asp_params.svh constants are visible to users.
package asp_pkg;
   typedef logic [31:0] asp_word_t;
   typedef logic [23:0] asp_smp_t;
   typedef enum logic [3:0]
   {
      ASP_IDLE = 4'h1,
      ASP_S0 = 4'h2,
      ASP_S1 = 4'h4,
      ASP_S2 = 4'h8
   } asp_state_e;
   typedef enum logic [1:0]
   {
      ASP_M_OFF = 2'h0,
      ASP_M_ALL = 2'h1,
      ASP_M_PAIR = 2'h2
   } asp_mode_e;
endpackage

// >>> design/asp_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
// Assumes one clock, asynchronous active-low reset.
`timescale 1ns/1ps
module asp_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 32
) (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_wr_valid,
   output logic o_wr_ready,
   input wire logic [WIDTH-1:0] i_wr_data,
   output logic o_rd_valid,
   input wire logic i_rd_ready,
   output logic [WIDTH-1:0] o_rd_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0] cnt_q;
   logic wr;
   logic rd;
   assign o_wr_ready = (cnt_q != (AW+1)'(DEPTH));
   assign o_rd_valid = (cnt_q != '0);
   assign o_rd_data = mem_q[rp_q];
   assign wr = i_wr_valid && o_wr_ready;
   assign rd = o_rd_valid && i_rd_ready;
   always_ff @(posedge i_core_clk)
   begin
      if (wr)
      begin
         mem_q[wp_q] <= i_wr_data;
      end
   end
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (wr)
         begin
            wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
         end
         if (rd)
         begin
            rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
         end
         if (wr && !rd)
         begin
            cnt_q <= cnt_q + 1'b1;
         end
         else if (rd && !wr)
         begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule

// >>> design/asp_packer.sv
// Audio sample packer: 16 kHz channel snapshots into a 48 kHz stereo stream.
// Assumes a pipeline strobe per 16 kHz period and a 48 kHz slot strobe.
//
// Contract
// RL1 - Snapshot several 16 kHz channels into one 48 kHz stream.
// RL2 - Pack only while output rate is 48 kHz; else emit nothing.
// RL3 - Three output slots per 16 kHz input period.
// RL4 - Receiver passes samples unchanged, no volume scaling.
// RL5 - Source 16 on both USB channels gives full capture there.
// RL6 - Full capture resolves channel indices itself, six over two.
// RL7 - Order: mic0, mic1, ref left, ref right, out0, out1.
// RL8 - Source 16 on I2S channels 2 and 3 gives full capture.
// RL9 - I2S packed words are always 32 bits.
// RL10 - Host sets USB output to 24-bit for full capture.
// RL11 - Output, mic and ref pair modes share one packing function.
// RL12 - Pair modes need a bit-exact 32-bit path.
// RL13 - Word 0: top 24 bits of first sample, marker 0x00.
// RL14 - Word 1: top 24 bits of second sample, marker 0x01.
// RL15 - Word 2: low bytes of both samples, zero, marker 0x02.
// RL16 - Unpacker finds markers 0x00, 0x01, 0x02 in low bytes.
// RL17 - Full capture uses low-byte slot markers for realignment.
`timescale 1ns/1ps
`include "asp_params.svh"
module asp_packer
   import asp_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_smp_strobe,
   input wire logic i_slot_strobe,
   input wire logic [1:0] i_out_rate,
   input wire logic [4:0] i_usb_src_l,
   input wire logic [4:0] i_usb_src_r,
   input wire logic [4:0] i_i2s_src_l,
   input wire logic [4:0] i_i2s_src_r,
   input wire logic [31:0] i_mic0,
   input wire logic [31:0] i_mic1,
   input wire logic [31:0] i_ref_l,
   input wire logic [31:0] i_ref_r,
   input wire logic [31:0] i_out0,
   input wire logic [31:0] i_out1,
   input wire logic i_usb_ready,
   output logic o_usb_valid,
   output logic [31:0] o_usb_left,
   output logic [31:0] o_usb_right,
   input wire logic i_i2s_ready,
   output logic o_i2s_valid,
   output logic [31:0] o_i2s_left,
   output logic [31:0] o_i2s_right,
   output logic o_overrun
);
   asp_state_e st_q;
   logic [31:0] snap_q [6];
   logic [63:0] fifo_in;
   logic [63:0] fifo_out;
   logic f_wr_ready;
   logic f_rd_valid;
   logic f_rd_ready;
   logic [1:0] slot;
   logic push;
   logic [31:0] u_l;
   logic [31:0] u_r;
   logic [31:0] s_l;
   logic [31:0] s_r;
   logic rate_ok;
   logic usb_all;
   logic i2s_all;
   logic usb_on;
   logic i2s_on;
   asp_mode_e usb_mode;
   asp_mode_e i2s_mode;
   logic i2s_free;
   logic f_wr_valid;

   // Shared pair packer: one 32-bit word per slot
   function automatic asp_word_t pack_pair(input logic [31:0] a,
                                           input logic [31:0] b,
                                           input logic [1:0] sl);
      asp_word_t w;
      w = 32'h0;
      case (sl)
         2'h0: w = {a[31:8], `ASP_MARK_0}; // [RL13] [RL11]
         2'h1: w = {b[31:8], `ASP_MARK_1}; // [RL14]
         2'h2: w = {a[7:0], b[7:0], 8'h00, `ASP_MARK_2}; // [RL15] [RL12]
         default: w = 32'h0;
      endcase
      return w;
   endfunction

   // Full capture: 24 bits of audio over a slot-numbered low byte,
   // so both channels carry three of the six channels per period
   function automatic asp_word_t pack_all(input logic [31:0] v,
                                          input logic [1:0] sl,
                                          input logic right);
      asp_word_t w;
      w = {v[31:8], `ASP_ALL_MARK_BASE | {5'h0, right, sl}}; // [RL17]
      return w;
   endfunction

   // Per-channel word for a routing source
   function automatic asp_word_t route(input logic [4:0] src,
                                       input logic right,
                                       input logic [1:0] sl,
                                       input logic [31:0] s0,
                                       input logic [31:0] s1,
                                       input logic [31:0] s2,
                                       input logic [31:0] s3,
                                       input logic [31:0] s4,
                                       input logic [31:0] s5);
      asp_word_t w;
      logic [31:0] pick;
      w = 32'h0;
      pick = 32'h0;
      case (src)
         `ASP_SRC_PACKED_ALL:
         begin
            // Left carries mic0,mic1,ref l; right ref r,out0,out1
            case ({right, sl})
               3'h0: pick = s0;
               3'h1: pick = s1;
               3'h2: pick = s2;
               3'h4: pick = s3;
               3'h5: pick = s4;
               3'h6: pick = s5;
               default: pick = 32'h0;
            endcase
            w = pack_all(pick, sl, right); // [RL6] [RL7]
         end
         `ASP_SRC_PAIR_OUT: w = pack_pair(s4, s5, sl); // [RL11]
         `ASP_SRC_PAIR_MIC: w = pack_pair(s0, s1, sl); // [RL11]
         `ASP_SRC_PAIR_REF: w = pack_pair(s2, s3, sl); // [RL11]
         default: w = 32'h0;
      endcase
      return w;
   endfunction

   // Both channels must name one source; a mixed pair is refused
   function automatic asp_mode_e src_mode(input logic [4:0] l,
                                          input logic [4:0] r);
      asp_mode_e m;
      m = ASP_M_OFF;
      if (l == r)
      begin
         case (l)
            `ASP_SRC_PACKED_ALL: m = ASP_M_ALL;
            `ASP_SRC_PAIR_OUT: m = ASP_M_PAIR;
            `ASP_SRC_PAIR_MIC: m = ASP_M_PAIR;
            `ASP_SRC_PAIR_REF: m = ASP_M_PAIR;
            default: m = ASP_M_OFF;
         endcase
      end
      return m;
   endfunction

   assign rate_ok = (i_out_rate == `ASP_RATE_48K); // [RL2]
   assign usb_mode = src_mode(i_usb_src_l, i_usb_src_r);
   assign i2s_mode = src_mode(i_i2s_src_l, i_i2s_src_r);
   assign usb_all = (usb_mode == ASP_M_ALL); // [RL5]
   assign i2s_all = (i2s_mode == ASP_M_ALL); // [RL8]
   assign usb_on = rate_ok && (usb_all || (usb_mode == ASP_M_PAIR));
   assign i2s_on = rate_ok && (i2s_all || (i2s_mode == ASP_M_PAIR)); // [RL8]

   // Slot sequencer: one period of three 48 kHz slots
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         st_q <= ASP_IDLE;
      end
      else if (!rate_ok)
      begin
         st_q <= ASP_IDLE; // [RL2]
      end
      else
      begin
         case (st_q)
            ASP_IDLE: if (i_smp_strobe) st_q <= ASP_S0;
            ASP_S0: if (push) st_q <= ASP_S1; // [RL3]
            ASP_S1: if (push) st_q <= ASP_S2;
            ASP_S2: if (push) st_q <= ASP_IDLE;
            default: st_q <= ASP_IDLE;
         endcase
      end
   end

   // Snapshot taken once per 16 kHz period
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         for (int i = 0; i < 6; i++)
         begin
            snap_q[i] <= 32'h0;
         end
      end
      else if (i_smp_strobe && st_q == ASP_IDLE)
      begin
         snap_q[0] <= i_mic0; // [RL1]
         snap_q[1] <= i_mic1;
         snap_q[2] <= i_ref_l;
         snap_q[3] <= i_ref_r;
         snap_q[4] <= i_out0;
         snap_q[5] <= i_out1;
      end
   end

   // A strobe during an unfinished period is ignored and raises o_overrun
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_overrun <= 1'b0;
      end
      else
      begin
         o_overrun <= i_smp_strobe && st_q != ASP_IDLE;
      end
   end

   always_comb
   begin
      slot = 2'h0;
      case (st_q)
         ASP_S0: slot = 2'h0;
         ASP_S1: slot = 2'h1;
         ASP_S2: slot = 2'h2;
         default: slot = 2'h3;
      endcase
   end

   // Stalls on a full FIFO or an unaccepted I2S word, so no slot is lost;
   // a slow I2S receiver therefore paces the USB side as well
   assign i2s_free = !o_i2s_valid || i_i2s_ready || !i2s_on;
   assign push = (st_q != ASP_IDLE) && i_slot_strobe && f_wr_ready
                 && i2s_free;
   assign f_wr_valid = push && usb_on;

   always_comb
   begin
      u_l = 32'h0;
      u_r = 32'h0;
      s_l = 32'h0;
      s_r = 32'h0;
      if (usb_on)
      begin
         u_l = route(i_usb_src_l, 1'b0, slot, snap_q[0], snap_q[1],
                     snap_q[2], snap_q[3], snap_q[4], snap_q[5]);
         u_r = route(i_usb_src_r, 1'b1, slot, snap_q[0], snap_q[1],
                     snap_q[2], snap_q[3], snap_q[4], snap_q[5]);
      end
      if (i2s_on)
      begin
         s_l = route(i_i2s_src_l, 1'b0, slot, snap_q[0], snap_q[1],
                     snap_q[2], snap_q[3], snap_q[4], snap_q[5]);
         s_r = route(i_i2s_src_r, 1'b1, slot, snap_q[0], snap_q[1],
                     snap_q[2], snap_q[3], snap_q[4], snap_q[5]);
      end
   end
   assign fifo_in = {u_l, u_r};

   asp_fifo #(
      .WIDTH(64),
      .DEPTH(`ASP_FIFO_DEPTH)
   ) u_fifo (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_wr_valid(f_wr_valid),
      .o_wr_ready(f_wr_ready),
      .i_wr_data(fifo_in),
      .o_rd_valid(f_rd_valid),
      .i_rd_ready(f_rd_ready),
      .o_rd_data(fifo_out)
   );

   // USB output register fed from the FIFO
   assign f_rd_ready = !o_usb_valid || i_usb_ready;
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_usb_valid <= 1'b0;
      end
      else if (f_rd_ready)
      begin
         o_usb_valid <= f_rd_valid;
      end
   end

   // Data moves only with a word, so unwritten FIFO cells never leak out
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_usb_left <= 32'h0;
         o_usb_right <= 32'h0;
      end
      else if (f_rd_ready && f_rd_valid)
      begin
         o_usb_left <= fifo_out[63:32];
         o_usb_right <= fifo_out[31:0];
      end
   end

   // I2S path is fixed 32-bit words, sent directly per slot
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_i2s_valid <= 1'b0;
      end
      else if (push && i2s_on)
      begin
         o_i2s_valid <= 1'b1;
      end
      else if (i_i2s_ready)
      begin
         o_i2s_valid <= 1'b0;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_i2s_left <= 32'h0;
         o_i2s_right <= 32'h0;
      end
      else if (push && i2s_on)
      begin
         o_i2s_left <= s_l; // [RL9] [RL8]
         o_i2s_right <= s_r;
      end
   end
endmodule

// >>> testbench/asp_packer_asserts.sv
// Port assertions for the audio sample packer.
// Assumes a bind from the testbench onto asp_packer.
`timescale 1ns/1ps
`include "asp_params.svh"
module asp_packer_asserts (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_smp_strobe,
   input wire logic i_slot_strobe,
   input wire logic [1:0] i_out_rate,
   input wire logic [4:0] i_usb_src_l,
   input wire logic [4:0] i_usb_src_r,
   input wire logic [4:0] i_i2s_src_l,
   input wire logic [4:0] i_i2s_src_r,
   input wire logic i_i2s_ready,
   input wire logic o_usb_valid,
   input wire logic [31:0] o_usb_left,
   input wire logic [31:0] o_usb_right,
   input wire logic o_i2s_valid,
   input wire logic [31:0] o_i2s_left,
   input wire logic o_overrun
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   logic usb_all;
   logic usb_pair;
   logic i2s_pair;
   assign usb_all = i_usb_src_l == `ASP_SRC_PACKED_ALL
      && i_usb_src_r == `ASP_SRC_PACKED_ALL;
   assign usb_pair = i_usb_src_l == i_usb_src_r
      && i_usb_src_l >= `ASP_SRC_PAIR_OUT && i_usb_src_l <= `ASP_SRC_PAIR_REF;
   assign i2s_pair = i_i2s_src_l == i_i2s_src_r
      && i_i2s_src_l >= `ASP_SRC_PAIR_OUT && i_i2s_src_l <= `ASP_SRC_PAIR_REF;
   a_rate_gate: assert property ($rose(o_i2s_valid) |->
      $past(i_out_rate) == `ASP_RATE_48K) else $error("word at wrong rate");
   a_slot_cause: assert property ($rose(o_i2s_valid) |->
      $past(i_slot_strobe)) else $error("word without slot strobe");
   a_i2s_hold: assert property (o_i2s_valid && !i_i2s_ready |=>
      o_i2s_valid && $stable(o_i2s_left)) else $error("word dropped");
   a_pair_mark: assert property (o_i2s_valid && i2s_pair |->
      o_i2s_left[7:0] <= `ASP_MARK_2) else $error("bad pair marker");
   a_pair_gap: assert property (o_i2s_valid && i2s_pair
      && o_i2s_left[7:0] == `ASP_MARK_2 |-> o_i2s_left[15:8] == 8'h00)
      else $error("pair third word gap not zero");
   a_full_left: assert property (o_usb_valid && usb_all |->
      o_usb_left[7:2] == 6'h04 && o_usb_left[1:0] != 2'h3)
      else $error("bad left full marker");
   a_full_right: assert property (o_usb_valid && usb_all |->
      o_usb_right[7:2] == 6'h05 && o_usb_right[1:0] == o_usb_left[1:0])
      else $error("bad right full marker");
   a_usb_gate: assert property ($rose(o_usb_valid) |->
      usb_all || usb_pair) else $error("usb word from unpacked source");
   a_overrun_cause: assert property (o_overrun |->
      $past(i_smp_strobe)) else $error("overrun without strobe");
   cover property (o_overrun);
   cover property (o_usb_valid && usb_all);
   cover property (o_i2s_valid && i2s_pair);
endmodule

// >>> testbench/asp_host_sink.sv
// Host capture model on the USB side of the packer.
// Assumes one clock; ready moves just after the rising edge.
`timescale 1ns/1ps
module asp_host_sink (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_stall,
   input wire logic i_valid,
   input wire logic [31:0] i_left,
   input wire logic [31:0] i_right,
   output logic o_ready
);
   logic [31:0] q_l[$];
   logic [31:0] q_r[$];
   always @(posedge i_core_clk or negedge i_rst_n)
      if (!i_rst_n)
         o_ready <= 1'b0;
      else
      begin
         // Whole words kept, no scaling or narrowing
         if (i_valid && o_ready)
         begin
            q_l.push_back(i_left);
            q_r.push_back(i_right);
         end
         o_ready <= !i_stall;
      end
endmodule

// >>> testbench/testbench.sv
// Self-checking bench for the audio sample packer.
// Assumes asp_packer, asp_fifo and the host sink model are compiled.
`timescale 1ns/1ps
`include "asp_params.svh"
module testbench;
   import asp_pkg::*;
   logic clk = 0, rst_n = 0, smp = 0, slot = 0, stall = 0, i2s_rdy = 1;
   logic [1:0] rate = `ASP_RATE_48K;
   logic [4:0] usrc = 5'h00, isrc = 5'h00;
   logic [31:0] ch[6] = '{default: 32'h0};
   logic usb_rdy, usb_v, i2s_v, ovr;
   logic [31:0] usb_l, usb_r, i2s_l, i2s_r;
   logic [31:0] iq_l[$];
   logic [31:0] iq_r[$];
   int bad_count = 0, num_checks = 0, ovr_cnt = 0;
   always #10 clk = ~clk;
   asp_packer dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_smp_strobe(smp),
      .i_slot_strobe(slot), .i_out_rate(rate), .i_usb_src_l(usrc),
      .i_usb_src_r(usrc), .i_i2s_src_l(isrc), .i_i2s_src_r(isrc),
      .i_mic0(ch[0]), .i_mic1(ch[1]), .i_ref_l(ch[2]), .i_ref_r(ch[3]),
      .i_out0(ch[4]), .i_out1(ch[5]), .i_usb_ready(usb_rdy),
      .o_usb_valid(usb_v), .o_usb_left(usb_l), .o_usb_right(usb_r),
      .i_i2s_ready(i2s_rdy), .o_i2s_valid(i2s_v), .o_i2s_left(i2s_l),
      .o_i2s_right(i2s_r), .o_overrun(ovr));
   asp_host_sink host (.i_core_clk(clk), .i_rst_n(rst_n), .i_stall(stall),
      .i_valid(usb_v), .i_left(usb_l), .i_right(usb_r), .o_ready(usb_rdy));
   always @(posedge clk)
   begin
      if (i2s_v && i2s_rdy)
      begin
         iq_l.push_back(i2s_l);
         iq_r.push_back(i2s_r);
      end
      if (ovr === 1'b1)
         ovr_cnt++;
   end
   task automatic step();
      @(posedge clk);
      #1;
   endtask
   task automatic cmp(input string nm, input logic [31:0] e,
      input logic [31:0] s);
      num_checks++;
      if (s !== e)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   function automatic logic [31:0] smpv(input int c, input int k);
      return {4'(c), 28'h9ABCDEF} + 32'(k);
   endfunction
   function automatic logic [31:0] fullw(input int k, input int s,
      input bit r);
      logic [31:0] x;
      x = smpv(r ? 3 + s : s, k);
      return {x[31:8], `ASP_ALL_MARK_BASE | {5'h00, r, 2'(s)}};
   endfunction
   function automatic logic [31:0] pairw(input logic [31:0] a,
      input logic [31:0] b, input int s);
      if (s == 0)
         return {a[31:8], `ASP_MARK_0};
      if (s == 1)
         return {b[31:8], `ASP_MARK_1};
      return {a[7:0], b[7:0], 8'h00, `ASP_MARK_2};
   endfunction
   task automatic clr();
      iq_l.delete();
      iq_r.delete();
      host.q_l.delete();
      host.q_r.delete();
      ovr_cnt = 0;
   endtask
   // One 16 kHz period: snapshot, then three slots; ov adds a late strobe
   task automatic run_period(input int k, input bit ov);
      for (int c = 0; c < 6; c++)
         ch[c] = smpv(c, k);
      smp = 1;
      step();
      smp = 0;
      for (int s = 0; s < 3; s++)
      begin
         slot = 1;
         if (s == 0 && ov)
            smp = 1;
         step();
         slot = 0;
         smp = 0;
         repeat (4) step();
      end
   endtask
   // Bounded wait; a hang ends the run through the report
   task automatic wait_words(input int n);
      int i;
      for (i = 0; i < 300; i++)
      begin
         if (host.q_l.size() >= n && iq_l.size() >= n)
            break;
         step();
      end
      if (i == 300)
      begin
         bad_count++;
         $display("[FAIL] word count expected %0d seen %0d", n,
            host.q_l.size());
         final_report();
      end
   endtask
   task automatic t_full();
      clr();
      usrc = `ASP_SRC_PACKED_ALL;
      isrc = `ASP_SRC_PACKED_ALL;
      run_period(1, 1);
      wait_words(3);
      for (int s = 0; s < 3; s++)
      begin
         cmp("usb left", fullw(1, s, 0), host.q_l[s]);
         cmp("usb right", fullw(1, s, 1), host.q_r[s]);
         cmp("i2s left", fullw(1, s, 0), iq_l[s]);
         cmp("i2s right", fullw(1, s, 1), iq_r[s]);
      end
      cmp("overruns", 32'h1, 32'(ovr_cnt));
   endtask
   task automatic t_pair();
      int a;
      for (int code = 19; code <= 21; code++)
      begin
         clr();
         usrc = 5'(code);
         isrc = 5'(code);
         a = code == 19 ? 4 : (code == 20 ? 0 : 2);
         run_period(code, 0);
         wait_words(3);
         for (int s = 0; s < 3; s++)
         begin
            cmp("usb pair", pairw(smpv(a, code), smpv(a + 1, code), s),
               host.q_l[s]);
            cmp("usb pair right", pairw(smpv(a, code), smpv(a + 1, code),
               s), host.q_r[s]);
            cmp("i2s pair", pairw(smpv(a, code), smpv(a + 1, code), s),
               iq_l[s]);
         end
      end
   endtask
   task automatic t_rate();
      clr();
      usrc = `ASP_SRC_PACKED_ALL;
      isrc = `ASP_SRC_PACKED_ALL;
      rate = 2'h2;
      run_period(5, 0);
      repeat (40) step();
      cmp("usb words at other rate", 32'h0, 32'(host.q_l.size()));
      cmp("i2s words at other rate", 32'h0, 32'(iq_l.size()));
      rate = `ASP_RATE_48K;
   endtask
   task automatic t_stall();
      clr();
      stall = 1;
      run_period(10, 0);
      run_period(11, 0);
      cmp("usb words while stalled", 32'h0, 32'(host.q_l.size()));
      stall = 0;
      wait_words(6);
      for (int w = 0; w < 6; w++)
      begin
         cmp("usb after stall", fullw(10 + w / 3, w % 3, 0),
            host.q_l[w]);
         cmp("usb right after stall", fullw(10 + w / 3, w % 3, 1),
            host.q_r[w]);
      end
   endtask
   // I2S receiver holds off: the word stands and later slots wait
   task automatic t_hold();
      clr();
      usrc = `ASP_SRC_PAIR_MIC;
      isrc = `ASP_SRC_PAIR_MIC;
      i2s_rdy = 0;
      run_period(30, 0);
      cmp("i2s words while held", 32'h0, 32'(iq_l.size()));
      cmp("i2s valid while held", 32'h1, 32'(i2s_v));
      cmp("usb words while held", 32'h1, 32'(host.q_l.size()));
      i2s_rdy = 1;
      for (int s = 0; s < 2; s++)
      begin
         slot = 1;
         step();
         slot = 0;
         repeat (4) step();
      end
      wait_words(3);
      for (int s = 0; s < 3; s++)
      begin
         cmp("i2s after hold", pairw(smpv(0, 30), smpv(1, 30), s),
            iq_l[s]);
         cmp("usb after hold", pairw(smpv(0, 30), smpv(1, 30), s),
            host.q_l[s]);
      end
   endtask
   initial
   begin
      repeat (20) @(posedge clk);
      #1;
      rst_n = 1;
      step();
      t_full();
      t_pair();
      t_rate();
      t_stall();
      t_hold();
      final_report();
   end
endmodule
bind asp_packer asp_packer_asserts u_chk (.i_core_clk(i_core_clk),
   .i_rst_n(i_rst_n), .i_smp_strobe(i_smp_strobe),
   .i_slot_strobe(i_slot_strobe), .i_out_rate(i_out_rate),
   .i_usb_src_l(i_usb_src_l), .i_usb_src_r(i_usb_src_r),
   .i_i2s_src_l(i_i2s_src_l), .i_i2s_src_r(i_i2s_src_r),
   .i_i2s_ready(i_i2s_ready), .o_usb_valid(o_usb_valid),
   .o_usb_left(o_usb_left), .o_usb_right(o_usb_right),
   .o_i2s_valid(o_i2s_valid), .o_i2s_left(o_i2s_left),
   .o_overrun(o_overrun));
